// File: iexu_params.svh
// Offsets, field positions, reset values and timing counts of the integer unit
`ifndef IEXU_PARAMS_SVH
`define IEXU_PARAMS_SVH
`define IEXU_GPR_OFF 12'h000
`define IEXU_XER_OFF 12'h080
`define IEXU_CR_OFF 12'h084
`define IEXU_STAT_OFF 12'h088
`define IEXU_XER_SO_BIT 31
`define IEXU_XER_OV_BIT 30
`define IEXU_XER_CA_BIT 29
`define IEXU_STAT_BUSY_BIT 0
`define IEXU_XER_RST 3'h0
`define IEXU_CR_RST 32'h00000000
`define IEXU_DIV_STEPS 6'h20
`endif

// File: iexu_pkg.sv
// Types of the integer execution unit
package iexu_pkg;
  typedef enum logic [5:0] {
    OP_ADD = 6'h00, OP_SUB_FROM = 6'h01, OP_ADD_CARRY = 6'h02, OP_SUB_CARRY = 6'h03,
    OP_ADD_EXT = 6'h04, OP_SUB_EXT = 6'h05, OP_ADD_M1_EXT = 6'h06, OP_SUB_M1_EXT = 6'h07,
    OP_ADD_Z_EXT = 6'h08, OP_SUB_Z_EXT = 6'h09, OP_NEGATE = 6'h0A, OP_MUL_LO = 6'h0B,
    OP_MUL_HI_S = 6'h0C, OP_MUL_HI_U = 6'h0D, OP_DIV_S = 6'h0E, OP_DIV_U = 6'h0F,
    OP_CMP_S = 6'h10, OP_CMP_U = 6'h11, OP_AND = 6'h12, OP_OR = 6'h13, OP_XOR = 6'h14,
    OP_NAND = 6'h15, OP_NOR = 6'h16, OP_EQV = 6'h17, OP_ANDC = 6'h18, OP_ORC = 6'h19,
    OP_SEXT_B = 6'h1A, OP_SEXT_H = 6'h1B, OP_CLZ = 6'h1C, OP_ROT_AND = 6'h1D,
    OP_ROT_INS = 6'h1E, OP_SHL = 6'h1F, OP_SHR = 6'h20, OP_SHRA = 6'h21
  } iexu_op_t;

  typedef enum logic [2:0] {
    BSEL_REG = 3'h0, BSEL_SIGNED_IMM16 = 3'h1, BSEL_UNSIGNED_IMM16 = 3'h2, BSEL_SIGNED_IMM16_HI = 3'h3, BSEL_UNSIGNED_IMM16_HI = 3'h4
  } iexu_bsel_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0, ST_EXEC = 2'h1, ST_DIVW = 2'h2
  } iexu_st_t;

  typedef struct packed {
    iexu_op_t op;
    iexu_bsel_t bsel;
    logic [4:0] src_a;
    logic [4:0] src_b;
    logic [4:0] dst;
    logic [15:0] imm;
    logic [4:0] sh;
    logic sh_imm;
    logic [4:0] mb;
    logic [4:0] me;
    logic rec;
    logic oe;
    logic [2:0] cfield;
    logic trace_pend;
  } iexu_issue_t;

  typedef struct packed {
    logic [31:0] data;
    logic [4:0] dst;
    logic gpr_wr;
    logic discarded;
  } iexu_cpl_t;

  typedef struct packed {
    logic so;
    logic ov;
    logic ca;
  } iexu_xer_t;

  typedef struct packed {
    iexu_st_t st;
    iexu_issue_t op;
    logic act;
    logic [31:0][31:0] general_reg_file;
    iexu_xer_t integer_exception_reg;
    logic [31:0] cr;
    iexu_cpl_t cpl;
    logic cpl_valid;
    logic apb_hold;
    logic [31:0] prdata;
  } iexu_state_t;

  typedef struct packed {
    logic busy;
    logic done;
    logic [5:0] cnt;
    logic [31:0] rem;
    logic [31:0] quo;
    logic [31:0] dvs;
    logic neg_q;
    logic ovf;
    logic [31:0] res;
  } iexu_div_state_t;
endpackage

// File: iexu_div.sv
// Iterative word divider, one quotient bit per cycle
`timescale 1ns/10ps
`include "iexu_params.svh"
module iexu_div (
  input logic sys_clk_i,
  input logic nrst_i,
  input logic start_i,
  input logic signed_i,
  input logic [31:0] dividend_i,
  input logic [31:0] divisor_i,
  output logic busy_o,
  output logic done_o,
  output logic [31:0] quot_o,
  output logic ovf_o
);
  iexu_pkg::iexu_div_state_t cur, nx;
  logic [32:0] trial;
  logic [31:0] qnew;
  logic take;

  assign trial = {cur.rem, cur.quo[31]};
  assign take = trial >= {1'b0, cur.dvs};

  always_comb begin
    nx = cur;
    nx.done = 1'b0;
    qnew = {cur.quo[30:0], take};
    if (start_i) begin
      nx.busy = 1'b1;
      nx.cnt = `IEXU_DIV_STEPS;
      nx.rem = 32'h0;
      nx.neg_q = signed_i & (dividend_i[31] ^ divisor_i[31]);
      nx.quo = (signed_i & dividend_i[31]) ? 32'(-dividend_i) : dividend_i;
      nx.dvs = (signed_i & divisor_i[31]) ? 32'(-divisor_i) : divisor_i;
      // Quotient is left undefined in these cases; only the flag is meaningful
      nx.ovf = (divisor_i == 32'h0) |
               (signed_i & (dividend_i == 32'h80000000) & (divisor_i == 32'hFFFFFFFF));
    end else if (cur.busy) begin
      nx.rem = take ? 32'(trial - {1'b0, cur.dvs}) : trial[31:0];
      nx.quo = qnew;
      nx.cnt = cur.cnt - 6'h1;
      if (cur.cnt == 6'h1) begin
        nx.busy = 1'b0;
        nx.done = 1'b1;
        nx.res = cur.neg_q ? 32'(-qnew) : qnew;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      cur <= '0;
    end else begin
      cur <= nx;
    end
  end

  assign busy_o = cur.busy;
  assign done_o = cur.done;
  assign quot_o = cur.res;
  assign ovf_o = cur.ovf;
endmodule

// File: iexu_top.sv
// Integer execution unit: dispatch port, general register file, flags, APB access
//
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/10ps
`include "iexu_params.svh"
//
// Summary of operation
// - Operands from register file, results to file/flags/fields
// - Reverse subtract yields second source minus first
// - Overflow recording sets summary and overflow flags
// - Slow flag-setting ops may stall the next
// - Compare operand: zero-extended, sign-extended, or register
// - Plain compare signed, logical compare unsigned
// - Compare writes selected field, field zero default
// - Record logicals and AND-immediates update field zero
// - Logicals leave summary, overflow, carry flags
// - OR-immediate zero no-op discarded unless trace pending
// - Mask insert: masked bits rotated, others kept
// - Rotate then AND with generated mask
// - Rotate immediate/register amounts with mask begin/end
// - Logical and arithmetic shifts by register or immediate
// - Extended single-source add/subtract with minus one, zero, negate
// - Multiply low, high signed and unsigned
// - Count leading zeros, byte and halfword sign extension
// - Record variants update condition register, others not
// - Overflow variants alone may change overflow flag
module iexu_top (
  input logic SYS_CLK_I,
  input logic NRST_I,
  input logic ISSUE_VALID_I,
  input iexu_pkg::iexu_issue_t ISSUE_I,
  output logic ISSUE_READY_O,
  output logic CPL_VALID_O,
  output iexu_pkg::iexu_cpl_t CPL_O,
  output iexu_pkg::iexu_xer_t EXC_REG_O,
  output logic [31:0] COND_REG_O,
  input logic PSEL_I,
  input logic PENABLE_I,
  input logic PWRITE_I,
  input logic [11:0] PADDR_I,
  input logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O
);
  iexu_pkg::iexu_state_t cur, nx;
  iexu_pkg::iexu_op_t op;
  logic [31:0] opa, opb, old, ax, ay, res, rot, mask, lmask, sra, div_q, rd_mux;
  logic [31:0] cr_keep, fmask;
  logic [63:0] rot64, prod_u;
  logic signed [63:0] prod_s;
  logic [32:0] sum;
  logic [4:0] ramt;
  logic [5:0] samt;
  logic cin, inv_a, is_ext, wr_ca, ov_cap, is_logic, is_cmp, is_div, ovf, ca_out;
  logic lt, gt, eq, new_so, rec_eff, nop, wb_now, div_start, div_done, div_ovf;
  logic apb_rdy, apb_wr, unmapped, is_gpr_addr, div_enter;

  function automatic logic [5:0] f_clz(input logic [31:0] v);
    logic [5:0] n;
    logic hit;
    n = 6'h20;
    hit = 1'b0;
    for (int k = 31; k >= 0; k--) begin
      if (!hit && v[k]) begin
        n = 6'(31 - k);
        hit = 1'b1;
      end
    end
    return n;
  endfunction

  assign op = cur.op.op;
  assign opa = cur.general_reg_file[cur.op.src_a];
  assign old = cur.general_reg_file[cur.op.dst];

  always_comb begin
    unique case (cur.op.bsel)
      iexu_pkg::BSEL_REG: opb = cur.general_reg_file[cur.op.src_b];
      iexu_pkg::BSEL_SIGNED_IMM16: opb = {{16{cur.op.imm[15]}}, cur.op.imm};
      iexu_pkg::BSEL_UNSIGNED_IMM16: opb = {16'h0, cur.op.imm};
      iexu_pkg::BSEL_SIGNED_IMM16_HI: opb = {cur.op.imm, 16'h0};
      iexu_pkg::BSEL_UNSIGNED_IMM16_HI: opb = {cur.op.imm, 16'h0};
      default: opb = 32'h0;
    endcase
  end

  // Adder operand steering; every subtract is the complement of the first source plus one, or plus the carry flag for extended ones
  assign inv_a = op inside {iexu_pkg::OP_SUB_FROM, iexu_pkg::OP_SUB_CARRY, iexu_pkg::OP_SUB_EXT,
                            iexu_pkg::OP_SUB_M1_EXT, iexu_pkg::OP_SUB_Z_EXT, iexu_pkg::OP_NEGATE};
  assign is_ext = op inside {[iexu_pkg::OP_ADD_EXT:iexu_pkg::OP_SUB_Z_EXT]};
  assign wr_ca = is_ext | (op inside {iexu_pkg::OP_ADD_CARRY, iexu_pkg::OP_SUB_CARRY,
                                      iexu_pkg::OP_SHRA});
  assign ov_cap = op inside {[iexu_pkg::OP_ADD:iexu_pkg::OP_MUL_LO], iexu_pkg::OP_DIV_S,
                             iexu_pkg::OP_DIV_U};
  assign is_logic = op inside {[iexu_pkg::OP_AND:iexu_pkg::OP_CLZ]};
  assign is_cmp = op inside {iexu_pkg::OP_CMP_S, iexu_pkg::OP_CMP_U};
  assign is_div = op inside {iexu_pkg::OP_DIV_S, iexu_pkg::OP_DIV_U};

  assign ax = inv_a ? ~opa : opa;
  always_comb begin
    if (op inside {iexu_pkg::OP_ADD_M1_EXT, iexu_pkg::OP_SUB_M1_EXT}) begin
      ay = 32'hFFFFFFFF;
    end else if (op inside {iexu_pkg::OP_ADD_Z_EXT, iexu_pkg::OP_SUB_Z_EXT,
                            iexu_pkg::OP_NEGATE}) begin
      ay = 32'h0;
    end else begin
      ay = opb;
    end
  end
  assign cin = is_ext ? cur.integer_exception_reg.ca : (op inside {iexu_pkg::OP_SUB_FROM, iexu_pkg::OP_SUB_CARRY,
                                                 iexu_pkg::OP_NEGATE});
  assign sum = {1'b0, ax} + {1'b0, ay} + {32'h0, cin};

  assign prod_s = $signed(opa) * $signed(opb);
  assign prod_u = {32'h0, opa} * {32'h0, opb};

  assign ramt = cur.op.sh_imm ? cur.op.sh : opb[4:0];
  assign rot64 = {opa, opa} << ramt;
  assign rot = rot64[63:32];
  generate
    for (genvar i = 0; i < 32; i++) begin : g_mask
      localparam logic [4:0] POS = 5'(i);
      // Bit 0 is the most significant; a begin past the end wraps the mask around
      assign mask[31 - i] = (cur.op.mb <= cur.op.me) ?
                            (POS >= cur.op.mb && POS <= cur.op.me) :
                            (POS >= cur.op.mb || POS <= cur.op.me);
    end
  endgenerate

  assign samt = cur.op.sh_imm ? {1'b0, cur.op.sh} : opb[5:0];
  assign sra = samt[5] ? {32{opa[31]}} : 32'($signed(opa) >>> samt[4:0]);
  assign lmask = samt[5] ? 32'hFFFFFFFF : ~(32'hFFFFFFFF << samt[4:0]);

  always_comb begin
    unique case (op)
      iexu_pkg::OP_MUL_LO: res = prod_s[31:0];
      iexu_pkg::OP_MUL_HI_S: res = prod_s[63:32];
      iexu_pkg::OP_MUL_HI_U: res = prod_u[63:32];
      iexu_pkg::OP_DIV_S, iexu_pkg::OP_DIV_U: res = div_q;
      iexu_pkg::OP_AND: res = opa & opb;
      iexu_pkg::OP_OR: res = opa | opb;
      iexu_pkg::OP_XOR: res = opa ^ opb;
      iexu_pkg::OP_NAND: res = ~(opa & opb);
      iexu_pkg::OP_NOR: res = ~(opa | opb);
      iexu_pkg::OP_EQV: res = ~(opa ^ opb);
      iexu_pkg::OP_ANDC: res = opa & ~opb;
      iexu_pkg::OP_ORC: res = opa | ~opb;
      iexu_pkg::OP_SEXT_B: res = {{24{opa[7]}}, opa[7:0]};
      iexu_pkg::OP_SEXT_H: res = {{16{opa[15]}}, opa[15:0]};
      iexu_pkg::OP_CLZ: res = {26'h0, f_clz(opa)};
      iexu_pkg::OP_ROT_AND: res = rot & mask;
      iexu_pkg::OP_ROT_INS: res = (rot & mask) | (old & ~mask);
      iexu_pkg::OP_SHL: res = samt[5] ? 32'h0 : (opa << samt[4:0]);
      iexu_pkg::OP_SHR: res = samt[5] ? 32'h0 : (opa >> samt[4:0]);
      iexu_pkg::OP_SHRA: res = sra;
      default: res = sum[31:0];
    endcase
  end

  always_comb begin
    if (op == iexu_pkg::OP_MUL_LO) begin
      ovf = (prod_s[63:31] != {33{1'b0}}) && (prod_s[63:31] != {33{1'b1}});
    end else if (is_div) begin
      ovf = div_ovf;
    end else begin
      ovf = (ax[31] == ay[31]) && (sum[31] != ax[31]);
    end
  end
  // Carry of an arithmetic right shift: negative source lost some one bits
  assign ca_out = (op == iexu_pkg::OP_SHRA) ? (opa[31] && ((opa & lmask) != 32'h0)) : sum[32];

  always_comb begin
    if (op == iexu_pkg::OP_CMP_U) begin
      lt = opa < opb;
      gt = opa > opb;
    end else begin
      lt = $signed(opa) < $signed(opb);
      gt = $signed(opa) > $signed(opb);
    end
  end
  assign eq = opa == opb;

  assign nop = (ISSUE_I.op == iexu_pkg::OP_OR) && (ISSUE_I.src_a == 5'h0) &&
               (ISSUE_I.dst == 5'h0) && (ISSUE_I.bsel == iexu_pkg::BSEL_UNSIGNED_IMM16) &&
               (ISSUE_I.imm == 16'h0) && !ISSUE_I.trace_pend;
  assign new_so = cur.integer_exception_reg.so | (cur.op.oe & ov_cap & ovf);
  assign rec_eff = cur.op.rec | ((op == iexu_pkg::OP_AND) &&
                                 (cur.op.bsel != iexu_pkg::BSEL_REG));
  assign wb_now = ((cur.st == iexu_pkg::ST_EXEC) && cur.act && !is_div) ||
                  ((cur.st == iexu_pkg::ST_DIVW) && div_done);
  assign fmask = 32'hF0000000 >> {cur.op.cfield, 2'b00};
  assign cr_keep = cur.cr & ~fmask;
  assign div_enter = (cur.st == iexu_pkg::ST_EXEC) && cur.act && is_div;

  // Register file access is stalled for the write-back cycle and one more, so a
  // read never returns a value that the unit is overwriting at the same edge
  assign apb_rdy = !wb_now && !cur.apb_hold;
  assign apb_wr = PSEL_I && PENABLE_I && PWRITE_I && apb_rdy && !unmapped;
  assign is_gpr_addr = PADDR_I < `IEXU_XER_OFF;
  assign unmapped = PADDR_I > `IEXU_STAT_OFF;

  always_comb begin
    rd_mux = 32'h0;
    if (is_gpr_addr) begin
      rd_mux = cur.general_reg_file[PADDR_I[6:2]];
    end else if (PADDR_I[11:2] == `IEXU_XER_OFF / 4) begin
      rd_mux[`IEXU_XER_SO_BIT] = cur.integer_exception_reg.so;
      rd_mux[`IEXU_XER_OV_BIT] = cur.integer_exception_reg.ov;
      rd_mux[`IEXU_XER_CA_BIT] = cur.integer_exception_reg.ca;
    end else if (PADDR_I[11:2] == `IEXU_CR_OFF / 4) begin
      rd_mux = cur.cr;
    end else if (PADDR_I[11:2] == `IEXU_STAT_OFF / 4) begin
      rd_mux[`IEXU_STAT_BUSY_BIT] = cur.st != iexu_pkg::ST_IDLE;
      rd_mux[2:1] = cur.st;
    end
  end

  always_comb begin
    nx = cur;
    nx.cpl_valid = 1'b0;
    nx.apb_hold = wb_now;
    nx.prdata = rd_mux;
    div_start = 1'b0;
    unique case (cur.st)
      iexu_pkg::ST_IDLE: begin
        if (ISSUE_VALID_I) begin
          nx.op = ISSUE_I;
          nx.act = !nop;
          nx.st = iexu_pkg::ST_EXEC;
        end
      end
      iexu_pkg::ST_EXEC: begin
        if (!cur.act) begin
          nx.st = iexu_pkg::ST_IDLE;
          nx.cpl_valid = 1'b1;
          nx.cpl.data = 32'h0;
          nx.cpl.dst = cur.op.dst;
          nx.cpl.gpr_wr = 1'b0;
          nx.cpl.discarded = 1'b1;
        end else if (is_div) begin
          div_start = 1'b1;
          nx.st = iexu_pkg::ST_DIVW;
        end
      end
      iexu_pkg::ST_DIVW: ;
      default: nx.st = iexu_pkg::ST_IDLE;
    endcase
    if (wb_now) begin
      nx.st = iexu_pkg::ST_IDLE;
      nx.cpl_valid = 1'b1;
      nx.cpl.data = res;
      nx.cpl.dst = cur.op.dst;
      nx.cpl.gpr_wr = !is_cmp;
      nx.cpl.discarded = 1'b0;
      if (!is_cmp) begin
        nx.general_reg_file[cur.op.dst] = res;
      end
      if (cur.op.oe && ov_cap) begin
        nx.integer_exception_reg.ov = ovf;
        nx.integer_exception_reg.so = new_so;
      end
      if (wr_ca) begin
        nx.integer_exception_reg.ca = ca_out;
      end
      if (is_cmp) begin
        nx.cr[{~cur.op.cfield, 2'b11} -: 4] = {lt, gt, eq, new_so};
      end else if (rec_eff) begin
        nx.cr[31:28] = {res[31], !res[31] && (res != 32'h0), res == 32'h0, new_so};
      end
    end
    if (apb_wr) begin
      if (is_gpr_addr) begin
        nx.general_reg_file[PADDR_I[6:2]] = PWDATA_I;
      end else if (PADDR_I[11:2] == `IEXU_XER_OFF / 4) begin
        nx.integer_exception_reg.so = PWDATA_I[`IEXU_XER_SO_BIT];
        nx.integer_exception_reg.ov = PWDATA_I[`IEXU_XER_OV_BIT];
        nx.integer_exception_reg.ca = PWDATA_I[`IEXU_XER_CA_BIT];
      end else if (PADDR_I[11:2] == `IEXU_CR_OFF / 4) begin
        nx.cr = PWDATA_I;
      end
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      cur <= '0;
      cur.integer_exception_reg <= `IEXU_XER_RST;
      cur.cr <= `IEXU_CR_RST;
    end else begin
      cur <= nx;
    end
  end

  iexu_div u_div (
    .sys_clk_i(SYS_CLK_I),
    .nrst_i(NRST_I),
    .start_i(div_start),
    .signed_i(op == iexu_pkg::OP_DIV_S),
    .dividend_i(opa),
    .divisor_i(opb),
    .busy_o(),
    .done_o(div_done),
    .quot_o(div_q),
    .ovf_o(div_ovf)
  );

  assign ISSUE_READY_O = cur.st == iexu_pkg::ST_IDLE;
  assign CPL_VALID_O = cur.cpl_valid;
  assign CPL_O = cur.cpl;
  assign EXC_REG_O = cur.integer_exception_reg;
  assign COND_REG_O = cur.cr;
  assign PRDATA_O = cur.prdata;
  assign PREADY_O = apb_rdy;
  assign PSLVERR_O = PSEL_I && PENABLE_I && apb_rdy && unmapped;

  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!NRST_I);

  property p_sub_from;
    wb_now && (op == iexu_pkg::OP_SUB_FROM) |=> CPL_O.data == $past(opb) - $past(opa);
  endproperty
  a_sub_from: assert property (p_sub_from) else $error("reverse subtract wrong");

  property p_ov_keep;
    wb_now && !cur.op.oe |=> EXC_REG_O.ov == $past(EXC_REG_O.ov);
  endproperty
  a_ov_keep: assert property (p_ov_keep) else $error("overflow changed without oe");

  property p_logic_flags;
    wb_now && is_logic |=> EXC_REG_O == $past(EXC_REG_O);
  endproperty
  a_logic_flags: assert property (p_logic_flags) else $error("logical op touched flags");

  property p_no_rec;
    wb_now && !rec_eff && !is_cmp |=> COND_REG_O == $past(COND_REG_O);
  endproperty
  a_no_rec: assert property (p_no_rec) else $error("condition reg changed");

  property p_cmp_field;
    wb_now && is_cmp |=> (COND_REG_O & ~$past(fmask)) == $past(cr_keep);
  endproperty
  a_cmp_field: assert property (p_cmp_field) else $error("compare hit other fields");

  property p_busy;
    !ISSUE_READY_O |-> ##[1:40] ISSUE_READY_O;
  endproperty
  a_busy: assert property (p_busy) else $error("unit stalled too long");

  property p_nop;
    ISSUE_VALID_I && ISSUE_READY_O && nop |=> !cur.act ##1 CPL_VALID_O && CPL_O.discarded;
  endproperty
  a_nop: assert property (p_nop) else $error("no-op not discarded");

  property p_ins;
    (cur.st == iexu_pkg::ST_EXEC) && (op == iexu_pkg::OP_ROT_INS) |->
      (((res ^ rot) & mask) == 32'h0) && (((res ^ old) & ~mask) == 32'h0);
  endproperty
  a_ins: assert property (p_ins) else $error("mask insert wrong");

  property p_div_time;
    div_enter |=> (cur.st == iexu_pkg::ST_DIVW) [*8] ##[1:30] CPL_VALID_O;
  endproperty
  a_div_time: assert property (p_div_time) else $error("divide not completed");
endmodule

// File: iexu_disp_model.sv
// Dispatch and completion model that feeds operations to the integer unit
`timescale 1ns/10ps
module iexu_disp_model (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic go_i,
  input wire logic [3:0] lag_i,
  input iexu_pkg::iexu_issue_t req_i,
  input wire logic ready_i,
  input wire logic cpl_valid_i,
  input iexu_pkg::iexu_cpl_t cpl_i,
  output logic valid_o,
  output iexu_pkg::iexu_issue_t issue_o,
  output logic done_o,
  output iexu_pkg::iexu_cpl_t got_o
);
  logic pend;
  logic [3:0] wait_cnt;
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      pend <= 1'b0;
      wait_cnt <= 4'h0;
      valid_o <= 1'b0;
      issue_o <= '0;
      done_o <= 1'b0;
      got_o <= '0;
    end else begin
      done_o <= 1'b0;
      if (go_i) begin
        pend <= 1'b1;
        wait_cnt <= lag_i;
      end else if (pend && wait_cnt != 4'h0) begin
        wait_cnt <= wait_cnt - 4'h1;
      end else if (pend) begin
        pend <= 1'b0;
        valid_o <= 1'b1;
        issue_o <= req_i;
      end
      if (valid_o && ready_i) begin
        valid_o <= 1'b0;
        // Released fields flip so a stale operand cannot pass for a live one
        issue_o <= iexu_pkg::iexu_issue_t'(~issue_o);
      end
      if (cpl_valid_i) begin
        got_o <= cpl_i;
        done_o <= 1'b1;
      end
    end
  end
endmodule

// File: testbench.sv
// Self-checking testbench of the integer execution unit
`timescale 1ns/10ps
module testbench;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic go = 1'b0;
  logic [3:0] lag = 4'h0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic valid;
  logic ready;
  logic cpl_valid;
  logic done;
  logic [31:0] cr;
  logic [31:0] rdat;
  logic rerr;
  iexu_pkg::iexu_issue_t iss;
  iexu_pkg::iexu_issue_t req = '0;
  iexu_pkg::iexu_issue_t q;
  iexu_pkg::iexu_cpl_t cpl;
  iexu_pkg::iexu_cpl_t got;
  iexu_pkg::iexu_xer_t exc;
  int fail_count = 0;
  int check_count = 0;

  initial begin
    forever #5 clk = ~clk;
  end

  iexu_top dut (.SYS_CLK_I(clk), .NRST_I(nrst), .ISSUE_VALID_I(valid), .ISSUE_I(iss),
    .ISSUE_READY_O(ready), .CPL_VALID_O(cpl_valid), .CPL_O(cpl), .EXC_REG_O(exc),
    .COND_REG_O(cr), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr));

  iexu_disp_model model (.clk_i(clk), .nrst_i(nrst), .go_i(go), .lag_i(lag), .req_i(req),
    .ready_i(ready), .cpl_valid_i(cpl_valid), .cpl_i(cpl), .valid_o(valid),
    .issue_o(iss), .done_o(done), .got_o(got));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  function automatic logic [31:0] fld(input int k);
    return {28'h0, cr[31-4*k -: 4]};
  endfunction

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (n >= 20) chk("apb_wait", 32'h1, 32'h0);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [4:0] i, input logic [31:0] v);
    apb(1'b1, {5'h0, i, 2'h0}, v);
  endtask

  function automatic void mk(input iexu_pkg::iexu_op_t o, input logic [4:0] a,
      input logic [4:0] b, input logic [4:0] d);
    q = '0;
    q.op = o;
    q.src_a = a;
    q.src_b = b;
    q.dst = d;
  endfunction

  // Hands q to the dispatch model and waits for its completion
  task automatic run();
    int n;
    n = 0;
    req <= q;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    while (done !== 1'b1 && n < 80) begin
      @(posedge clk);
      n++;
    end
    if (n >= 80) chk("cpl_wait", 32'h1, 32'h0);
  endtask

  task automatic ex(input string nm, input logic [31:0] e);
    run();
    chk(nm, e, got.data);
  endtask

  task automatic t_apb();
    chk("cond_rst", 32'h0, cr);
    chk("flag_rst", 32'h0, {29'h0, exc});
    wr(5'h1F, 32'h5A5AA5A5);
    apb(1'b0, 12'h07C, 32'h0);
    chk("gpr31", 32'h5A5AA5A5, rdat);
    apb(1'b0, 12'h100, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, rerr});
    chk("unmapped_dat", 32'h0, rdat);
    $display("done t_apb");
  endtask

  task automatic rot(input iexu_pkg::iexu_op_t o, input logic [4:0] d, input logic si);
    mk(o, 5'h0A, 5'h0D, d);
    q.sh = 5'h08;
    q.sh_imm = si;
    q.mb = 5'h18;
    q.me = 5'h1F;
  endtask

  task automatic t_rot();
    lag <= 4'h3;
    wr(5'h0A, 32'h12345678);
    wr(5'h0B, 32'hAAAAAAAA);
    wr(5'h0D, 32'h00000008);
    wr(5'h0E, 32'hFFFFFFF0);
    rot(iexu_pkg::OP_ROT_AND, 5'h0C, 1'b1);
    ex("rot_and_imm", 32'h00000012);
    rot(iexu_pkg::OP_ROT_AND, 5'h0C, 1'b0);
    ex("rot_and_reg", 32'h00000012);
    rot(iexu_pkg::OP_ROT_INS, 5'h0B, 1'b1);
    ex("rot_ins", 32'hAAAAAA12);
    mk(iexu_pkg::OP_SHL, 5'h0A, 5'h0D, 5'h0F);
    ex("shl", 32'h34567800);
    mk(iexu_pkg::OP_SHR, 5'h0A, 5'h0D, 5'h0F);
    ex("shr", 32'h00123456);
    mk(iexu_pkg::OP_SHRA, 5'h0E, 5'h00, 5'h0F);
    q.sh = 5'h02;
    q.sh_imm = 1'b1;
    ex("shra_imm", 32'hFFFFFFFC);
    lag <= 4'h0;
    $display("done t_rot");
  endtask

  task automatic t_misc();
    iexu_pkg::iexu_op_t ops[18] = '{iexu_pkg::OP_CLZ, iexu_pkg::OP_SEXT_B,
      iexu_pkg::OP_SEXT_H, iexu_pkg::OP_MUL_LO, iexu_pkg::OP_MUL_HI_S, iexu_pkg::OP_MUL_HI_U,
      iexu_pkg::OP_DIV_S, iexu_pkg::OP_DIV_U, iexu_pkg::OP_NEGATE, iexu_pkg::OP_ADD_Z_EXT,
      iexu_pkg::OP_SUB_M1_EXT, iexu_pkg::OP_SUB_Z_EXT, iexu_pkg::OP_ADD_M1_EXT,
      iexu_pkg::OP_MUL_LO, iexu_pkg::OP_XOR, iexu_pkg::OP_EQV, iexu_pkg::OP_ANDC,
      iexu_pkg::OP_ORC};
    logic [4:0] srca[18] = '{5'h12, 5'h12, 5'h12, 5'h10, 5'h10, 5'h10, 5'h10, 5'h10,
      5'h11, 5'h11, 5'h11, 5'h11, 5'h11, 5'h11, 5'h12, 5'h12, 5'h12, 5'h12};
    logic [31:0] exps[18] = '{32'h10, 32'hFFFFFF80, 32'hFFFF8080, 32'hFFFFFFEB,
      32'hFFFFFFFF, 32'h2, 32'hFFFFFFFE, 32'h55555553, 32'hFFFFFFFD, 32'h3,
      32'hFFFFFFFB, 32'hFFFFFFFD, 32'h2, 32'hFFFFFFFA, 32'h8083, 32'hFFFF7F7C, 32'h8080,
      32'hFFFFFFFC};
    wr(5'h10, 32'hFFFFFFF9);
    wr(5'h11, 32'h00000003);
    wr(5'h12, 32'h00008080);
    for (int i = 0; i < 18; i++) begin
      mk(ops[i], srca[i], 5'h11, 5'h13);
      if (i == 13) begin
        q.bsel = iexu_pkg::BSEL_SIGNED_IMM16;
        q.imm = 16'hFFFE;
      end
      ex("misc_op", exps[i]);
    end
    chk("ca_after_ext", 32'h1, {31'h0, exc.ca});
    $display("done t_misc");
  endtask

  task automatic t_carry();
    wr(5'h01, 32'hFFFFFFFF);
    wr(5'h02, 32'h00000001);
    mk(iexu_pkg::OP_ADD_CARRY, 5'h01, 5'h02, 5'h03);
    ex("addc", 32'h0);
    chk("addc_ca", 32'h1, {31'h0, exc.ca});
    mk(iexu_pkg::OP_ADD_EXT, 5'h02, 5'h02, 5'h03);
    ex("adde", 32'h3);
    chk("adde_ca", 32'h0, {31'h0, exc.ca});
    mk(iexu_pkg::OP_SUB_CARRY, 5'h02, 5'h01, 5'h03);
    ex("subfc", 32'hFFFFFFFE);
    chk("subfc_ca", 32'h1, {31'h0, exc.ca});
    $display("done t_carry");
  endtask

  task automatic t_logic();
    wr(5'h01, 32'h0000F0F0);
    mk(iexu_pkg::OP_AND, 5'h01, 5'h00, 5'h07);
    q.bsel = iexu_pkg::BSEL_UNSIGNED_IMM16;
    q.imm = 16'h0F00;
    ex("andi", 32'h0);
    chk("andi_cr0", 32'h2, fld(0));
    chk("logic_flags", 32'h1, {29'h0, exc});
    mk(iexu_pkg::OP_NOR, 5'h01, 5'h01, 5'h08);
    ex("nor", 32'hFFFF0F0F);
    chk("nor_cr0", 32'h2, fld(0));
    q.rec = 1'b1;
    ex("nor_rec", 32'hFFFF0F0F);
    chk("nor_rec_cr0", 32'h8, fld(0));
    chk("nor_flags", 32'h1, {29'h0, exc});
    $display("done t_logic");
  endtask

  task automatic t_cmp();
    wr(5'h01, 32'hFFFFFFFF);
    wr(5'h09, 32'h00000001);
    mk(iexu_pkg::OP_CMP_S, 5'h01, 5'h09, 5'h00);
    q.cfield = 3'h3;
    run();
    chk("cmp_s_reg", 32'h8, fld(3));
    q.op = iexu_pkg::OP_CMP_U;
    q.cfield = 3'h5;
    run();
    chk("cmp_u_reg", 32'h4, fld(5));
    q.op = iexu_pkg::OP_CMP_S;
    q.bsel = iexu_pkg::BSEL_SIGNED_IMM16;
    q.imm = 16'hFFFF;
    q.cfield = 3'h0;
    run();
    chk("cmp_s_imm", 32'h2, fld(0));
    q.op = iexu_pkg::OP_CMP_U;
    q.bsel = iexu_pkg::BSEL_UNSIGNED_IMM16;
    q.cfield = 3'h1;
    run();
    chk("cmp_u_imm", 32'h4, fld(1));
    $display("done t_cmp");
  endtask

  task automatic t_nop();
    mk(iexu_pkg::OP_OR, 5'h00, 5'h00, 5'h00);
    q.bsel = iexu_pkg::BSEL_UNSIGNED_IMM16;
    run();
    chk("nop_disc", 32'h1, {31'h0, got.discarded});
    chk("nop_wr", 32'h0, {31'h0, got.gpr_wr});
    q.trace_pend = 1'b1;
    run();
    chk("trace_disc", 32'h0, {31'h0, got.discarded});
    chk("trace_wr", 32'h1, {31'h0, got.gpr_wr});
    $display("done t_nop");
  endtask

  task automatic t_ovf();
    wr(5'h04, 32'h7FFFFFFF);
    wr(5'h05, 32'h00000001);
    mk(iexu_pkg::OP_ADD, 5'h04, 5'h05, 5'h06);
    ex("add", 32'h80000000);
    chk("add_flags", 32'h1, {29'h0, exc});
    q.oe = 1'b1;
    q.rec = 1'b1;
    ex("addo", 32'h80000000);
    chk("addo_flags", 32'h7, {29'h0, exc});
    chk("addo_dst", 32'h6, {27'h0, got.dst});
    chk("addo_cr0", 32'h9, fld(0));
    apb(1'b0, 12'h080, 32'h0);
    chk("flag_word", 32'hE0000000, rdat);
    apb(1'b0, 12'h018, 32'h0);
    chk("gpr6", 32'h80000000, rdat);
    mk(iexu_pkg::OP_SUB_FROM, 5'h05, 5'h04, 5'h07);
    ex("subf", 32'h7FFFFFFE);
    chk("subf_cr0", 32'h9, fld(0));
    $display("done t_ovf");
  endtask

  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_apb();
    t_rot();
    t_misc();
    t_carry();
    t_logic();
    t_cmp();
    t_nop();
    t_ovf();
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    stop_test();
  end
endmodule
